// >>> hw/fcsb_top.sv
// module: flash control register, space mapping, boot select and lock enforcement
`timescale 1ns/1ps
`default_nettype none
module fcsb_top #(
	parameter int PROGRAM_CYCLES = fcsb_pkg::program_cycles
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        sfr_write,
	input  wire logic        sfr_read,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	input  wire logic        external_data_move,
	input  wire logic        code_read_move,
	input  wire logic        fetch_external,
	input  wire logic [15:0] access_addr,
	output logic             route_flash_latch,
	output logic             route_flash_code,
	output logic             route_extra_page,
	output logic             route_security,
	output logic             write_blocked,
	output logic             external_read_blocked,
	output logic             external_exec_blocked,
	input  wire logic        external_access_pin,
	input  wire logic        program_strobe_pin,
	output logic      [15:0] boot_address,
	output logic             ea_latched,
	input  wire logic        pp_write_security,
	input  wire logic [7:0]  pp_security_wdata,
	input  wire logic        pp_chip_erase,
	input  wire logic        pp_program,
	input  wire logic        pp_verify,
	output logic             pp_program_ok,
	output logic             pp_verify_ok,
	output logic      [7:0]  pp_security_rdata,
	output logic             program_busy_flag
);
	if (PROGRAM_CYCLES < 4) begin : gen_bad_count
		$error("program count too short");
	end

	fcsb_prog_if prog ();
	logic [7:0] hardware_security_byte;

	fcsb_sequencer #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) fcsb_sequencer_inst (
		.clk   (clk),
		.rst_n (rst_n),
		.prog  (prog)
	);

	// only programmer pins reach the security store
	fcsb_security fcsb_security_inst (
		.clk           (clk),
		.rst_n         (rst_n),
		.pp_write      (pp_write_security),
		.pp_wdata      (pp_security_wdata),
		.pp_chip_erase (pp_chip_erase),
		.value         (hardware_security_byte)
	);

	// control register state
	logic [3:0] launch_code_nibble, next_launch;
	logic       program_space_map, next_map;
	logic [1:0] space_select, next_sel;
	logic       armed, next_armed;
	logic       start_q, next_start;
	logic       ctrl_hit;
	logic [3:0] wr_nib;

	assign ctrl_hit = sfr_write && (sfr_addr == fcsb_pkg::flash_control_addr);
	assign wr_nib   = sfr_wdata[7:fcsb_pkg::launch_lo];

	always_comb begin
		next_launch = launch_code_nibble;
		next_map    = program_space_map;
		next_sel    = space_select;
		next_armed  = armed;
		next_start  = 1'b0;
		if (ctrl_hit) begin
			next_launch = wr_nib;
			// remap ignored while busy so an operation keeps its target space
			if (!prog.busy) begin
				next_map = sfr_wdata[fcsb_pkg::map_bit];
				next_sel = sfr_wdata[fcsb_pkg::sel_lo +: 2];
			end
			if (armed && wr_nib == fcsb_pkg::launch_second && !prog.busy) begin
				next_start = 1'b1;
				next_armed = 1'b0;
			end else begin
				next_armed = (wr_nib == fcsb_pkg::launch_first);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			launch_code_nibble <= 4'h0;
			program_space_map  <= 1'b0;
			space_select       <= 2'h0;
			armed              <= 1'b0;
			start_q            <= 1'b0;
		end else begin
			launch_code_nibble <= next_launch;
			program_space_map  <= next_map;
			space_select       <= next_sel;
			armed              <= next_armed;
			start_q            <= next_start;
		end
	end
	assign prog.start = start_q;
	assign prog.space = space_select;

	// lock level decode: bits active low
	logic lvl2, lvl3, lvl4;
	assign lvl4 = !hardware_security_byte[2];
	assign lvl3 = lvl4 || !hardware_security_byte[1];
	assign lvl2 = lvl3 || !hardware_security_byte[0];

	// reset-time boot capture, done on the first clocked cycle after release
	logic       rst_seen, next_seen;
	logic [15:0] next_boot;
	logic        next_ea;
	always_comb begin
		next_seen = 1'b1;
		next_boot = boot_address;
		next_ea   = ea_latched;
		if (!rst_seen) begin
			if (external_access_pin && !program_strobe_pin) begin
				next_boot = fcsb_pkg::boot_loader;
			end else if (hardware_security_byte[fcsb_pkg::jump_bit]) begin
				next_boot = fcsb_pkg::boot_app;
			end else begin
				next_boot = fcsb_pkg::boot_loader;
			end
			next_ea = lvl2 ? external_access_pin : 1'b0;
		end
	end

	// outputs registered
	logic [7:0] next_rdata;
	logic       next_latch, next_code, next_extra, next_secsel;
	logic       next_wblk, next_rblk, next_xblk, next_pok, next_vok;
	logic       in_boot_seg;
	assign in_boot_seg = (access_addr >= fcsb_pkg::boot_seg_lo);

	always_comb begin
		next_rdata = 8'h00;
		if (sfr_read && sfr_addr == fcsb_pkg::flash_control_addr) begin
			next_rdata = {launch_code_nibble, program_space_map, space_select,
				prog.busy};
		end
		next_latch  = program_space_map && external_data_move;
		next_code   = program_space_map && code_read_move;
		next_extra  = program_space_map && space_select == fcsb_pkg::sel_extra;
		next_secsel = program_space_map && space_select == fcsb_pkg::sel_security;
		// software writes into boot segment dropped while lock active
		next_wblk   = program_space_map && external_data_move
			&& space_select == fcsb_pkg::sel_user && in_boot_seg
			&& !hardware_security_byte[fcsb_pkg::bootlock_bit];
		next_rblk   = lvl2 && fetch_external && code_read_move;
		next_xblk   = lvl4;
		next_pok    = pp_program && !lvl2;
		next_vok    = pp_verify && !lvl3;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rst_seen              <= 1'b0;
			boot_address          <= 16'h0000;
			ea_latched            <= 1'b0;
			sfr_rdata             <= 8'h00;
			route_flash_latch     <= 1'b0;
			route_flash_code      <= 1'b0;
			route_extra_page      <= 1'b0;
			route_security        <= 1'b0;
			write_blocked         <= 1'b0;
			external_read_blocked <= 1'b0;
			external_exec_blocked <= 1'b0;
			pp_program_ok         <= 1'b0;
			pp_verify_ok          <= 1'b0;
			pp_security_rdata     <= 8'h00;
			program_busy_flag     <= 1'b0;
		end else begin
			rst_seen              <= next_seen;
			boot_address          <= next_boot;
			ea_latched            <= next_ea;
			sfr_rdata             <= next_rdata;
			route_flash_latch     <= next_latch;
			route_flash_code      <= next_code;
			route_extra_page      <= next_extra;
			route_security        <= next_secsel;
			write_blocked         <= next_wblk;
			external_read_blocked <= next_rblk;
			external_exec_blocked <= next_xblk;
			pp_program_ok         <= next_pok;
			pp_verify_ok          <= next_vok;
			pp_security_rdata     <= hardware_security_byte;
			program_busy_flag     <= prog.busy;
		end
	end
endmodule : fcsb_top
`default_nettype wire

// >>> hw/fcsb_pkg.sv
// package: register map, fields, codes and timing for the flash control and security block
package fcsb_pkg;
	localparam logic [7:0] flash_control_addr = 8'hd1;
	localparam int         launch_lo          = 4;
	localparam logic [3:0] launch_first       = 4'h5;
	localparam logic [3:0] launch_second      = 4'ha;
	localparam int         map_bit            = 3;
	localparam int         sel_lo             = 1;
	localparam int         busy_bit           = 0;
	localparam logic [1:0] sel_user           = 2'h0;
	localparam logic [1:0] sel_extra          = 2'h1;
	localparam logic [1:0] sel_security       = 2'h2;
	localparam int         safe_bit           = 7;
	localparam int         jump_bit           = 6;
	localparam int         bootlock_bit       = 5;
	localparam logic [7:0] security_erased    = 8'hff;
	localparam logic [7:0] security_delivered = 8'h18;
	localparam logic [7:0] reserved_mask      = 8'h18;
	localparam logic [15:0] boot_app          = 16'h0000;
	localparam logic [15:0] boot_loader       = 16'hfc03;
	localparam logic [15:0] boot_seg_lo       = 16'hfc00;
	localparam int         page_bytes         = 128;
	localparam int         program_time_us    = 10000;
	localparam int         clk_mhz            = 100;
	localparam int         program_cycles     = program_time_us * clk_mhz;
	localparam logic [7:0] part_code          = 8'h3c; // arbitrary value
endpackage : fcsb_pkg

// >>> hw/fcsb_prog_if.sv
// interface: programming request from the control logic to the sequencer
`timescale 1ns/1ps
`default_nettype none
interface fcsb_prog_if;
	logic        start;
	logic [1:0]  space;
	logic        busy;
	logic        done;
	modport ctrl (output start, output space, input busy, input done);
	modport seq  (input start, input space, output busy, output done);
endinterface : fcsb_prog_if
`default_nettype wire

// >>> hw/fcsb_sequencer.sv
// module: timed erase-then-program sequencer
`timescale 1ns/1ps
`default_nettype none
module fcsb_sequencer #(
	parameter int PROGRAM_CYCLES = fcsb_pkg::program_cycles
) (
	input  wire logic  clk,
	input  wire logic  rst_n,
	fcsb_prog_if.seq   prog
);
	typedef enum logic [1:0] {
		fcsb_idle  = 2'b00,
		fcsb_erase = 2'b01,
		fcsb_write = 2'b10
	} fcsb_state_e;
	fcsb_state_e state, next_state;
	logic [31:0] count, next_count;
	logic        done_q, next_done;
	localparam logic [31:0] half = 32'(PROGRAM_CYCLES / 2);
	// both halves need at least two cycles each for the countdown to reach one
	if (PROGRAM_CYCLES < 4) begin : gen_bad_count
		$error("program count too short");
	end
	always_comb begin
		next_state = state;
		next_count = count;
		next_done  = 1'b0;
		unique case (state)
			fcsb_idle: if (prog.start) begin
				next_state = fcsb_erase;
				next_count = half;
			end
			fcsb_erase: if (count == 32'h1) begin
				next_state = fcsb_write;
				next_count = half;
			end else begin
				next_count = count - 32'h1;
			end
			fcsb_write: if (count == 32'h1) begin
				next_state = fcsb_idle;
				next_done  = 1'b1;
			end else begin
				next_count = count - 32'h1;
			end
			default: next_state = fcsb_idle;
		endcase
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state  <= fcsb_idle;
			count  <= 32'h0;
			done_q <= 1'b0;
		end else begin
			state  <= next_state;
			count  <= next_count;
			done_q <= next_done;
		end
	end
	assign prog.busy = (state != fcsb_idle);
	assign prog.done = done_q;
endmodule : fcsb_sequencer
`default_nettype wire

// >>> hw/fcsb_security.sv
// module: hardware security byte store and parallel-programmer write filter
`timescale 1ns/1ps
`default_nettype none
module fcsb_security (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       pp_write,
	input  wire logic [7:0] pp_wdata,
	input  wire logic       pp_chip_erase,
	output logic      [7:0] value
);
	// power-up value stands for the delivered fuse contents
	logic [7:0] hardware_security_byte = fcsb_pkg::security_delivered;
	logic [7:0] next_hsb;
	logic [2:0] merged;
	// higher level number means more protection: with safe_bit clear, bits 7:3 hold and lock bits 2:0 may only go 1 to 0
	always_comb begin
		next_hsb = hardware_security_byte;
		merged   = hardware_security_byte[2:0] & pp_wdata[2:0];
		if (pp_chip_erase) begin
			next_hsb = fcsb_pkg::security_erased;
		end else if (pp_write) begin
			if (hardware_security_byte[fcsb_pkg::safe_bit]) begin
				next_hsb = pp_wdata | fcsb_pkg::reserved_mask;
			end else begin
				next_hsb = {hardware_security_byte[7:3], merged};
			end
		end
	end
	// nonvolatile: system reset must not touch it, or the boot jump bit could never be seen set
	// programmer commands are ignored while reset is held
	always_ff @(posedge clk) begin
		if (rst_n) begin
			hardware_security_byte <= next_hsb;
		end
	end
	assign value = hardware_security_byte;
endmodule : fcsb_security
`default_nettype wire

// >>> tb/fcsb_monitor.sv
// checker: port-level properties of the flash control and security block
`timescale 1ns/1ps
`default_nettype none
module fcsb_monitor (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       sfr_write,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       external_data_move,
	input wire logic       fetch_external,
	input wire logic       pp_chip_erase,
	input wire logic       pp_program,
	input wire logic       pp_verify,
	input wire logic       route_flash_latch,
	input wire logic       external_exec_blocked,
	input wire logic       pp_program_ok,
	input wire logic       pp_verify_ok,
	input wire logic [7:0] pp_security_rdata,
	input wire logic       program_busy_flag
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic ctl = sfr_write && sfr_addr == 8'hd1;
	launch_busy_a: assert property (
		ctl && sfr_wdata[7:4] == 4'ha && $past(ctl && sfr_wdata[7:4] == 4'h5) && $past(rst_n)
		&& !program_busy_flag && !$past(program_busy_flag) |-> ##3 program_busy_flag)
		else $error("busy flag missing after launch");
	busy_hold_a: assert property (
		$rose(program_busy_flag) |-> program_busy_flag[*8]) else $error("busy dropped early");
	busy_end_a: assert property (
		$rose(program_busy_flag) |-> ##[8:10] !program_busy_flag) else $error("busy never cleared");
	latch_route_a: assert property (
		route_flash_latch |-> $past(external_data_move)) else $error("latch route without move");
	prog_gate_a: assert property (
		pp_program_ok |-> $past(pp_program) && pp_security_rdata[2:0] == 3'h7)
		else $error("programming allowed while locked");
	verify_gate_a: assert property (
		pp_verify_ok |-> $past(pp_verify) && pp_security_rdata[2:1] == 2'h3)
		else $error("verify allowed at level three or four");
	exec_block_a: assert property (
		$past(rst_n) && $past(fetch_external) && !pp_security_rdata[2] |-> external_exec_blocked)
		else $error("external execution not blocked");
	erase_value_a: assert property (
		pp_chip_erase |-> ##2 pp_security_rdata == 8'hff) else $error("erase left byte set");
endmodule // fcsb_monitor
`default_nettype wire

// >>> tb/fcsb_programmer.sv
// model: parallel programmer on the security byte port
`timescale 1ns/1ps
`default_nettype none
module fcsb_programmer (
	input  wire logic       clk,
	output logic            pp_write_security,
	output logic      [7:0] pp_security_wdata,
	output logic            pp_chip_erase,
	output logic            pp_program,
	output logic            pp_verify
);
	initial begin
		pp_write_security = 1'b0;
		pp_security_wdata = 8'h00;
		pp_chip_erase = 1'b0;
		pp_program = 1'b0;
		pp_verify = 1'b0;
	end
	task automatic write_byte(input logic [7:0] v);
		@(posedge clk) #1;
		pp_write_security = 1'b1;
		pp_security_wdata = v | 8'h18;
		@(posedge clk) #1;
		pp_write_security = 1'b0;
		// data no longer held once the strobe is gone
		pp_security_wdata = ~pp_security_wdata;
	endtask
	task automatic erase();
		@(posedge clk) #1;
		pp_chip_erase = 1'b1;
		@(posedge clk) #1;
		pp_chip_erase = 1'b0;
	endtask
	task automatic mode(input logic p, input logic r);
		@(posedge clk) #1;
		pp_program = p;
		pp_verify = r;
	endtask
endmodule // fcsb_programmer
`default_nettype wire

// >>> tb/fcsb_top_test.sv
// testbench: table and directed checks of the flash control block
`timescale 1ns/1ps
`default_nettype none
module fcsb_top_test;
	typedef struct packed {
		logic [7:0]  ctl;
		logic [15:0] addr;
		logic [2:0]  mv;
		logic [5:0]  exp;
	} fcsb_row_s;
	logic        clk, rst_n, sfr_write, sfr_read, fetch_external, ea_pin, strobe_pin, seen;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, pp_wdata, sec_rd;
	logic [15:0] access_addr, boot_address;
	logic        pp_wr, pp_erase, pp_prog, pp_ver, prog_ok, ver_ok, busy, ea_latched;
	logic        r_latch, r_code, r_extra, r_sec, w_blk, x_blk;
	logic        xdm, crm, r_rblk;
	int          error_cnt = 0;
	int          checks = 0;
	// mv is {data move, code read, external fetch}; exp is {latch, code, extra, sec, wblk, rblk}
	fcsb_row_s   rows [6] = '{'{8'h00, 16'hfc00, 3'h7, 6'h01}, '{8'h08, 16'h1234, 3'h6, 6'h30},
		'{8'h08, 16'hfc00, 3'h4, 6'h22}, '{8'h08, 16'hfbff, 3'h7, 6'h31},
		'{8'h0a, 16'h0100, 3'h6, 6'h38}, '{8'h0c, 16'h0100, 3'h3, 6'h15}};
	logic [7:0]  sw [5] = '{8'he7, 8'hfe, 8'h7d, 8'hff, 8'hfb};
	logic [7:0]  se [5] = '{8'h18, 8'hfe, 8'h7d, 8'h7d, 8'h79};
	logic [2:0]  sm [5] = '{3'h1, 3'h2, 3'h0, 3'h0, 3'h1};
	fcsb_top #(.PROGRAM_CYCLES(8)) fcsb_top_inst (.clk(clk), .rst_n(rst_n),
		.sfr_write(sfr_write), .sfr_read(sfr_read), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .external_data_move(xdm), .code_read_move(crm),
		.fetch_external(fetch_external), .access_addr(access_addr), .route_flash_latch(r_latch),
		.route_flash_code(r_code), .route_extra_page(r_extra), .route_security(r_sec),
		.write_blocked(w_blk), .external_read_blocked(r_rblk), .external_exec_blocked(x_blk),
		.external_access_pin(ea_pin), .program_strobe_pin(strobe_pin),
		.boot_address(boot_address), .ea_latched(ea_latched), .pp_write_security(pp_wr),
		.pp_security_wdata(pp_wdata), .pp_chip_erase(pp_erase), .pp_program(pp_prog),
		.pp_verify(pp_ver), .pp_program_ok(prog_ok), .pp_verify_ok(ver_ok),
		.pp_security_rdata(sec_rd), .program_busy_flag(busy));
	fcsb_programmer fcsb_programmer_inst (.clk(clk), .pp_write_security(pp_wr),
		.pp_security_wdata(pp_wdata), .pp_chip_erase(pp_erase), .pp_program(pp_prog),
		.pp_verify(pp_ver));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic step();
		@(posedge clk) #1;
	endtask
	// boot pins are set while reset is held and stay until the next reboot
	task automatic reboot(input logic ea, input logic ps);
		step();
		rst_n = 1'b0;
		ea_pin = ea;
		strobe_pin = ps;
		repeat (2) step();
		rst_n = 1'b1;
		repeat (3) step();
	endtask
	// writes stay raised so that a following write lands back to back
	task automatic wr(input logic [7:0] d);
		step();
		sfr_write = 1'b1;
		sfr_wdata = d;
	endtask
	task automatic rd(input logic [7:0] a);
		step();
		sfr_write = 1'b0;
		sfr_read = 1'b1;
		sfr_addr = a;
		step();
		sfr_read = 1'b0;
		sfr_addr = 8'hd1;
	endtask
	task automatic complete_run();
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#50000;
		error_cnt++;
		complete_run();
	end
	initial begin
		{rst_n, sfr_write, sfr_read, sfr_wdata, access_addr, fetch_external, strobe_pin} = '0;
		{xdm, crm} = 2'h0;
		sfr_addr = 8'hd1;
		ea_pin = 1'b1;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		rd(8'hd1);
		chk(sfr_rdata[3:0], 4'h0);
		chk(boot_address, 16'hfc03);
		chk(ea_latched, 1'b1);
		chk(sec_rd, 8'h18);
		rd(8'hd2);
		chk(sfr_rdata, 8'h00);
		for (int i = 0; i < 6; i++) begin
			wr(rows[i].ctl);
			rd(8'hd1);
			chk(sfr_rdata[3:0], rows[i].ctl[3:0]);
			access_addr = rows[i].addr;
			{xdm, crm, fetch_external} = rows[i].mv;
			step();
			chk({r_latch, r_code, r_extra, r_sec, w_blk, r_rblk}, rows[i].exp);
		end
		wr(8'h50);
		wr(8'ha0);
		rd(8'hd1);
		for (int i = 0; i < 6 && busy !== 1'b1; i++)
			step();
		chk(busy, 1'b1);
		wr(8'h0e);
		rd(8'hd1);
		chk(sfr_rdata[3:0], 4'h1);
		for (int i = 0; i < 20 && busy !== 1'b0; i++)
			step();
		chk(busy, 1'b0);
		wr(8'h50);
		wr(8'h30);
		wr(8'ha0);
		seen = 1'b0;
		repeat (12) begin
			step();
			sfr_write = 1'b0;
			seen = seen | busy;
		end
		chk(seen, 1'b0);
		fetch_external = 1'b1;
		fcsb_programmer_inst.mode(1'b1, 1'b1);
		for (int i = 0; i < 5; i++) begin
			if (i == 1) begin
				fcsb_programmer_inst.erase();
				repeat (2) step();
				chk(sec_rd, 8'hff);
				chk({prog_ok, ver_ok, x_blk}, 3'h6);
			end
			fcsb_programmer_inst.write_byte(sw[i]);
			repeat (2) step();
			chk(sec_rd, se[i]);
			chk({prog_ok, ver_ok, x_blk}, sm[i]);
		end
		reboot(1'b1, 1'b1);
		chk(boot_address, 16'h0000);
		chk(ea_latched, 1'b1);
		chk(sec_rd, 8'h79);
		reboot(1'b1, 1'b0);
		chk(boot_address, 16'hfc03);
		fcsb_programmer_inst.erase();
		reboot(1'b1, 1'b1);
		chk(ea_latched, 1'b0);
		chk(boot_address, 16'h0000);
		access_addr = 16'hfc00;
		{xdm, crm, fetch_external} = 3'h7;
		wr(8'h08);
		rd(8'hd1);
		chk({r_latch, r_code, r_extra, r_sec, w_blk, r_rblk}, 6'h30);
		complete_run();
	end
endmodule // fcsb_top_test
bind fcsb_top fcsb_monitor fcsb_monitor_inst (.clk(clk), .rst_n(rst_n), .sfr_write(sfr_write),
	.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .external_data_move(external_data_move),
	.fetch_external(fetch_external), .pp_chip_erase(pp_chip_erase), .pp_program(pp_program),
	.pp_verify(pp_verify), .route_flash_latch(route_flash_latch),
	.external_exec_blocked(external_exec_blocked), .pp_program_ok(pp_program_ok),
	.pp_verify_ok(pp_verify_ok), .pp_security_rdata(pp_security_rdata),
	.program_busy_flag(program_busy_flag));
`default_nettype wire
